/* File: design/wsb_pkg.sv */
// Package with timing constants and command codes for the word SRAM host controller.
package wsb_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    // Access timing of the slowest speed grade, in ns.
    localparam int READ_CYCLE_TIME_NS = 45;
    localparam int WRITE_CYCLE_TIME_NS = 35;
    localparam int DATA_SETUP_NS = 25;
    localparam int DATA_HOLD_NS = 2;
    localparam int ADDR_SETUP_NS = 2;
    localparam int ADDR_HOLD_NS = 3;
    localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
    localparam int RETENTION_RECOVERY_TIME_NS = READ_CYCLE_TIME_NS;
    // Least times round up to whole cycles, never below one.
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int READ_CYCLES = ns_to_cycles(READ_CYCLE_TIME_NS);
    localparam int WRITE_PULSE_CYCLES = ns_to_cycles(WRITE_CYCLE_TIME_NS);
    localparam int SETUP_CYCLES = ns_to_cycles(ADDR_SETUP_NS);
    localparam int HOLD_CYCLES = ns_to_cycles(ADDR_HOLD_NS);
    localparam int RETENTION_ENTRY_CYCLES = ns_to_cycles(DESELECT_TO_RETENTION_TIME_NS);
    localparam int RECOVERY_CYCLES = ns_to_cycles(RETENTION_RECOVERY_TIME_NS);
    localparam int CNT_W = 8;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    typedef enum logic [1:0] {
        WSB_CMD_READ,
        WSB_CMD_WRITE,
        WSB_CMD_SLEEP
    } wsb_cmd_t;
    typedef enum logic [3:0] {
        WSB_IDLE,
        WSB_RD_ACTIVE,
        WSB_RD_DONE,
        WSB_WR_SETUP,
        WSB_WR_PULSE,
        WSB_WR_HOLD,
        WSB_SLEEP_ENTRY,
        WSB_SLEEPING,
        WSB_RECOVER
    } wsb_state_t;
endpackage

/* File: design/wsb_host.sv */
// Host controller that drives a 64K x 16 asynchronous SRAM with byte lanes.
`timescale 1ns/100ps
module wsb_host
    import wsb_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       req_valid_in,
    input  wire wsb_pkg::wsb_cmd_t          req_cmd_in,
    input  wire logic [wsb_pkg::ADDR_W-1:0] req_addr_in,
    input  wire logic [wsb_pkg::DATA_W-1:0] req_wdata_in,
    input  wire logic [1:0]                 req_lanes_in,
    input  wire logic                       wake_in,
    output logic                            req_ready_out,
    output logic                            rsp_valid_out,
    output logic [wsb_pkg::DATA_W-1:0]      rsp_rdata_out,
    output logic                            retention_out,
    output logic [wsb_pkg::ADDR_W-1:0]      sram_addr_out,
    output logic                            chip_select_n_out,
    output logic                            upper_byte_select_n_out,
    output logic                            bottom_byte_select_n_out,
    output logic                            output_enable_n_out,
    output logic                            write_enable_n_out,
    output logic [wsb_pkg::DATA_W-1:0]      sram_data_out,
    output logic [wsb_pkg::DATA_W-1:0]      sram_data_oe_out,
    input  wire logic [wsb_pkg::DATA_W-1:0] sram_data_in
);
    import wsb_pkg::*;

    // The counter is loaded with a count minus one, so every count must fit its width.
    if (READ_CYCLES + 2 > (1 << CNT_W) || WRITE_PULSE_CYCLES > (1 << CNT_W)
        || RECOVERY_CYCLES > (1 << CNT_W))
    begin : g_count_check
        $error("Cycle counts exceed counter width.");
    end

    wsb_state_t            state;
    wsb_state_t            next_state;
    logic [CNT_W-1:0]      count;
    logic [CNT_W-1:0]      next_count;
    logic [1:0]            lanes;
    logic [DATA_W-1:0]     rd_sync1;
    logic [DATA_W-1:0]     rd_sync2;
    logic                  wake_sync1;
    logic                  wake_sync2;

    // Both lanes deselected would be a power-down access, so an empty mask means a word.
    wire logic [1:0] req_lane_mask = (req_lanes_in == 2'h0) ? 2'h3 : req_lanes_in;
    wire logic       take_req      = req_valid_in && req_ready_out;
    wire logic       count_done    = (count == '0);
    // Read data masked to the lanes that were enabled; the other lane floats at the pins.
    wire logic [DATA_W-1:0] lane_data = {lanes[1] ? rd_sync2[15:8] : 8'h00,
                                         lanes[0] ? rd_sync2[7:0]  : 8'h00};

    function automatic logic [CNT_W-1:0] load(input int cycles);
        return CNT_W'(cycles - 1);
    endfunction

    always_comb
    begin
        next_state = state;
        next_count = count_done ? count : count - 1'b1;
        case (state)
            WSB_IDLE:
                if (take_req)
                begin
                    case (req_cmd_in)
                        WSB_CMD_READ:
                        begin
                            next_state = WSB_RD_ACTIVE;
                            // Two extra cycles cover the input synchroniser.
                            next_count = load(READ_CYCLES + 2);
                        end
                        WSB_CMD_WRITE:
                        begin
                            next_state = WSB_WR_SETUP;
                            next_count = load(SETUP_CYCLES);
                        end
                        default:
                        begin
                            next_state = WSB_SLEEP_ENTRY;
                            next_count = load(RETENTION_ENTRY_CYCLES);
                        end
                    endcase
                end
            WSB_RD_ACTIVE:
                if (count_done)
                    next_state = WSB_RD_DONE;
            WSB_RD_DONE:
                next_state = WSB_IDLE;
            WSB_WR_SETUP:
                if (count_done)
                begin
                    next_state = WSB_WR_PULSE;
                    next_count = load(WRITE_PULSE_CYCLES);
                end
            WSB_WR_PULSE:
                if (count_done)
                begin
                    next_state = WSB_WR_HOLD;
                    next_count = load(HOLD_CYCLES);
                end
            WSB_WR_HOLD:
                if (count_done)
                    next_state = WSB_IDLE;
            WSB_SLEEP_ENTRY:
                if (count_done)
                    next_state = WSB_SLEEPING;
            WSB_SLEEPING:
                if (wake_sync2)
                begin
                    next_state = WSB_RECOVER;
                    next_count = load(RECOVERY_CYCLES);
                end
            WSB_RECOVER:
                if (count_done)
                    next_state = WSB_IDLE;
            default:
                next_state = WSB_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        rd_sync1   <= sram_data_in;
        rd_sync2   <= rd_sync1;
        wake_sync1 <= wake_in;
        wake_sync2 <= wake_sync1;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state <= WSB_IDLE;
            count <= '0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Address, lanes and write data latch when a request is taken and stay stable until idle.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sram_addr_out <= ADDR_RESET;
            lanes         <= 2'h0;
            sram_data_out <= DATA_RESET;
        end
        else if (take_req)
        begin
            sram_addr_out <= req_addr_in;
            lanes         <= req_lane_mask;
            sram_data_out <= req_wdata_in;
        end
    end

    // The selects of the enabled lanes open together with chip select and close with it.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            chip_select_n_out        <= 1'b1;
            upper_byte_select_n_out  <= 1'b1;
            bottom_byte_select_n_out <= 1'b1;
            output_enable_n_out      <= 1'b1;
            write_enable_n_out       <= 1'b1;
            sram_data_oe_out         <= '0;
        end
        else
        begin
            chip_select_n_out        <= !(next_state inside {WSB_RD_ACTIVE, WSB_WR_SETUP,
                                          WSB_WR_PULSE, WSB_WR_HOLD});
            upper_byte_select_n_out  <= !(next_state inside {WSB_RD_ACTIVE, WSB_WR_SETUP,
                                          WSB_WR_PULSE, WSB_WR_HOLD} &&
                                          (take_req ? req_lane_mask[1] : lanes[1]));
            bottom_byte_select_n_out <= !(next_state inside {WSB_RD_ACTIVE, WSB_WR_SETUP,
                                          WSB_WR_PULSE, WSB_WR_HOLD} &&
                                          (take_req ? req_lane_mask[0] : lanes[0]));
            output_enable_n_out      <= (next_state != WSB_RD_ACTIVE);
            // Write enable low only in the pulse state, so it ends the write.
            write_enable_n_out       <= (next_state != WSB_WR_PULSE);
            // Data held over setup, pulse and hold around the rising write enable.
            sram_data_oe_out         <= (next_state inside {WSB_WR_SETUP, WSB_WR_PULSE,
                                          WSB_WR_HOLD}) ? {DATA_W{1'b1}} : '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= DATA_RESET;
            retention_out <= 1'b0;
        end
        else
        begin
            req_ready_out <= (next_state == WSB_IDLE) && !take_req;
            rsp_valid_out <= (state == WSB_RD_ACTIVE) && count_done;
            if ((state == WSB_RD_ACTIVE) && count_done)
                rsp_rdata_out <= lane_data;
            retention_out <= (next_state == WSB_SLEEPING);
        end
    end
endmodule // wsb_host

/* File: verif/wsb_monitor.sv */
// Checker of the host-side pin rules of the word SRAM host controller.
`timescale 1ns/100ps
module wsb_monitor
    import wsb_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       retention_out,
    input  wire logic [wsb_pkg::ADDR_W-1:0] sram_addr_out,
    input  wire logic                       chip_select_n_out,
    input  wire logic                       upper_byte_select_n_out,
    input  wire logic                       bottom_byte_select_n_out,
    input  wire logic                       output_enable_n_out,
    input  wire logic                       write_enable_n_out,
    input  wire logic [wsb_pkg::DATA_W-1:0] sram_data_out,
    input  wire logic [wsb_pkg::DATA_W-1:0] sram_data_oe_out
);
    wire cs_n = chip_select_n_out;
    wire hi_n = upper_byte_select_n_out;
    wire lo_n = bottom_byte_select_n_out;
    wire oe_n = output_enable_n_out;
    wire we_n = write_enable_n_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    lane_follow_a: assert property (cs_n == (hi_n && lo_n))
        else $error("lane selects apart from chip select");
    we_in_cs_a: assert property (!we_n |-> !cs_n)
        else $error("write enable low while deselected");
    wr_data_a: assert property (!we_n |-> (&sram_data_oe_out) && $stable(sram_data_out))
        else $error("write data not steady under write enable");
    wr_hold_a: assert property ($rose(we_n) |-> !cs_n && $stable(sram_data_out))
        else $error("no data hold after write end");
    rd_no_we_a: assert property (!oe_n |-> we_n)
        else $error("write enable low in a read");
    rd_span_a: assert property ($fell(oe_n) |-> (!oe_n && we_n) [*8] ##1 (!oe_n && we_n) [*4])
        else $error("read cycle cut short");
    addr_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable(sram_addr_out))
        else $error("address moved in an access");
    ret_desel_a: assert property (retention_out |-> cs_n)
        else $error("selected while in retention");
    wake_gap_a: assert property ($fell(retention_out) |-> cs_n [*8] ##1 cs_n [*4])
        else $error("access too soon after wake");
    cover property ($rose(we_n) && !cs_n);
    cover property ($fell(oe_n));
    cover property ($fell(retention_out));
endmodule // wsb_monitor
bind wsb_host wsb_monitor u_wsb_monitor (.clk_in, .reset_in, .retention_out, .sram_addr_out,
    .chip_select_n_out, .upper_byte_select_n_out, .bottom_byte_select_n_out,
    .output_enable_n_out, .write_enable_n_out, .sram_data_out, .sram_data_oe_out);

/* File: verif/wsb_sram_model.sv */
// Behavioural model of the 64K x 16 byte-lane static RAM driven by the host.
`timescale 1ns/100ps
module wsb_sram_model
(
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        cs_n_in,
    input  wire logic        hi_n_in,
    input  wire logic        lo_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [15:0] host_data_in,
    input  wire logic [15:0] host_oe_in,
    output logic [15:0]      bus_out
);
    logic [15:0] mem [0:65535];
    logic [15:0] junk = 16'h5a5a;
    wire         sel = !cs_n_in && !(hi_n_in && lo_n_in);
    wire         wr_on = sel && !we_n_in;
    wire [15:0]  lanes = {{8{!hi_n_in}}, {8{!lo_n_in}}};
    wire [15:0]  drv = (sel && !oe_n_in && we_n_in) ? lanes : 16'h0000;
    // Released pins flip every cycle so a stale value can never pass for read data.
    always @(posedge clk_in)
        junk <= ~junk;
    // The store lands when the overlap of chip select and write enable ends.
    always @(negedge wr_on)
        mem[addr_in] <= (bus_out & lanes) | (mem[addr_in] & ~lanes);
    assign bus_out = (host_data_in & host_oe_in) | (mem[addr_in] & drv & ~host_oe_in)
                   | (junk & ~drv & ~host_oe_in);
endmodule // wsb_sram_model

/* File: verif/tb_wsb_host.sv */
// Self-checking bench for the word SRAM host controller.
`timescale 1ns/100ps
module tb_wsb_host;
    import wsb_pkg::*;
    logic        clk_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, wake_in = 1'b0;
    wsb_cmd_t    req_cmd_in = WSB_CMD_READ;
    logic [15:0] req_addr_in = 16'h0000, req_wdata_in = 16'h0000, rdata;
    logic [1:0]  req_lanes_in = 2'h3;
    logic        rdy, rv, ret, cs_n, hi_n, lo_n, oe_n, we_n;
    logic [15:0] rd, a, wd, woe, bus;
    int          error_cnt = 0, checked = 0;
    wsb_host u_wsb_host (.clk_in, .reset_in, .req_valid_in, .req_cmd_in, .req_addr_in,
        .req_wdata_in, .req_lanes_in, .wake_in, .req_ready_out(rdy), .rsp_valid_out(rv),
        .rsp_rdata_out(rd), .retention_out(ret), .sram_addr_out(a), .chip_select_n_out(cs_n),
        .upper_byte_select_n_out(hi_n), .bottom_byte_select_n_out(lo_n),
        .output_enable_n_out(oe_n), .write_enable_n_out(we_n), .sram_data_out(wd),
        .sram_data_oe_out(woe), .sram_data_in(bus));
    wsb_sram_model u_wsb_sram_model (.clk_in, .addr_in(a), .cs_n_in(cs_n), .hi_n_in(hi_n),
        .lo_n_in(lo_n), .oe_n_in(oe_n), .we_n_in(we_n), .host_data_in(wd), .host_oe_in(woe),
        .bus_out(bus));
    task automatic tally_and_finish;
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Holds the request until the edge that takes it, then waits for read data on a read.
    task automatic req(input wsb_cmd_t c, input logic [15:0] ad, input logic [15:0] d,
                       input logic [1:0] l);
        int n;
        n = 0;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_cmd_in <= c;
        req_addr_in <= ad;
        req_wdata_in <= d;
        req_lanes_in <= l;
        do @(posedge clk_in); while (rdy !== 1'b1 && ++n < 400);
        req_valid_in <= 1'b0;
        if (c == WSB_CMD_READ)
            do @(posedge clk_in); while (rv !== 1'b1 && ++n < 400);
        rdata = rd;
        chk({15'h0000, n < 400}, 16'h0001);
    endtask
    task automatic word_at_top;
        req(WSB_CMD_WRITE, 16'hffff, 16'ha5c3, 2'h3);
        req(WSB_CMD_READ, 16'hffff, 16'h0000, 2'h3);
        chk(rdata, 16'ha5c3);
    endtask
    task automatic byte_lanes;
        req(WSB_CMD_WRITE, 16'h0000, 16'h1234, 2'h3);
        req(WSB_CMD_WRITE, 16'h0000, 16'hffab, 2'h1);
        req(WSB_CMD_WRITE, 16'h0000, 16'hcdff, 2'h2);
        req(WSB_CMD_READ, 16'h0000, 16'h0000, 2'h3);
        chk(rdata, 16'hcdab);
        req(WSB_CMD_READ, 16'h0000, 16'h0000, 2'h1);
        chk(rdata, 16'h00ab);
        req(WSB_CMD_READ, 16'h0000, 16'h0000, 2'h2);
        chk(rdata, 16'hcd00);
        req(WSB_CMD_READ, 16'h0000, 16'h0000, 2'h0);
        chk(rdata, 16'hcdab);
    endtask
    task automatic sleep_wake;
        int n;
        n = 0;
        req(WSB_CMD_SLEEP, 16'h0000, 16'h0000, 2'h3);
        repeat (3) @(posedge clk_in);
        chk({15'h0000, ret && cs_n}, 16'h0001);
        wake_in <= 1'b1;
        do @(posedge clk_in); while (ret !== 1'b0 && ++n < 100);
        wake_in <= 1'b0;
        n = 0;
        do @(posedge clk_in); while (rdy !== 1'b1 && ++n < 100);
        chk({15'h0000, n >= READ_CYCLES - 1 && n < 100}, 16'h0001);
        req(WSB_CMD_READ, 16'hffff, 16'h0000, 2'h3);
        chk(rdata, 16'ha5c3);
    endtask
    initial
        forever #2 clk_in = ~clk_in;
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        word_at_top();
        byte_lanes();
        sleep_wake();
        tally_and_finish();
    end
    initial
    begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // tb_wsb_host
